// ---- logic_tile_regs.svh ----
// Constants of the logic tile: routing field positions and sizes.
// Assumes inclusion by bare name from the package, the fabric model and the bench.
`ifndef LOGIC_TILE_REGS_SVH
`define LOGIC_TILE_REGS_SVH
// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define LT_NUM_SLICES   4
`define LT_REG_SLICES   3
`define LT_LUT_IN       4
`define LT_LUT_BITS     16
`define LT_ROUTE_IN     50
`define LT_ROUTE_OUT    23
`define LT_SLICE_IN     13
`define LT_SLICE_OUT    6
// ---------------------------------------------------------------
// Field positions in a slice view
// ---------------------------------------------------------------
`define LT_M0           8
`define LT_M1           9
`define LT_CLKSEL       10
`define LT_CE           11
`define LT_LSR          12
`define LT_CTRL_W       3
// ---------------------------------------------------------------
// Field positions on the tile routing ports
// ---------------------------------------------------------------
`define LT_S3_BASE      39
`define LT_S3_USED      10
`define LT_WIDE_SEL     49
`define LT_S3_OUT_BASE  18
`define LT_CARRY_OUT    22
`endif

// ---- logic_tile_pkg.sv ----
// Types shared by the logic tile and its slices.
// Assumes the constants header is on the include path.
`include "logic_tile_regs.svh"
package logic_tile_pkg;
  typedef logic [`LT_LUT_BITS-1:0] table_t;
  typedef logic [`LT_SLICE_IN-1:0] slice_route_t;
  typedef enum logic {TILE_CONFIG, TILE_USER} tile_state_t;
endpackage : logic_tile_pkg

// ---- slice_if.sv ----
// Carrier between the tile and one slice.
// Assumes the package is compiled first.
`timescale 1ns/1ns
interface slice_if;
  logic_tile_pkg::slice_route_t route;
  logic                         carryIn;
  logic                         userMode;
  logic [1:0]                   clkNet;
  logic [1:0][`LT_LUT_BITS-1:0] tableInit;
  logic                         ripple;
  logic                         ramMode;
  logic                         clkInvert;
  logic                         latchMode;
  logic                         syncLsr;
  logic [1:0]                   initSet;
  logic [1:0]                   bypass;
  logic [1:0]                   f;
  logic                         ofx0;
  logic [1:0]                   q;
  logic                         carryOut;
  modport tile (output route, carryIn, userMode, clkNet, tableInit,
                ripple, ramMode, clkInvert, latchMode, syncLsr,
                initSet, bypass, input f, ofx0, q, carryOut);
  modport slice (input route, carryIn, userMode, clkNet, tableInit,
                 ripple, ramMode, clkInvert, latchMode, syncLsr,
                 initSet, bypass, output f, ofx0, q, carryOut);
endinterface : slice_if

// ---- logic_slice.sv ----
// One slice: two four_input_table cells, ripple carry, optional registers.
// Assumes the tile drives configuration through the slice interface.
`timescale 1ns/1ns
module logic_slice #(
  parameter bit HAS_REGS = 1'b1,
  parameter bit RAM_OK   = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Tile side
  slice_if.slice   sl
);
  logic_tile_pkg::table_t      mem [2];
  logic [1:0]                  lutOut;
  logic [1:0]                  wdata;
  logic [1:0]                  sum;
  logic                        mid;
  logic                        ramOn;
  logic                        we;

  assign wdata  = {sl.route[`LT_M1], sl.route[`LT_M0]};
  assign ramOn  = RAM_OK & sl.ramMode; // RL3
  assign we     = ramOn & sl.route[`LT_CE] & sl.userMode; // RL3

  // ---------------------------------------------------------------
  // Tables and distributed memory
  // ---------------------------------------------------------------
  for (genvar k = 0; k < 2; k++)
  begin : g_lut
    logic [`LT_LUT_IN-1:0] addr;
    assign addr      = sl.route[k*`LT_LUT_IN +: `LT_LUT_IN];
    assign lutOut[k] = mem[k][addr]; // RL1
    always_ff @(posedge clock or negedge reset_n)
    begin
      if (!reset_n)
        mem[k] <= '0;
      else if (!sl.userMode)
        mem[k] <= sl.tableInit[k];
      else if (we)
        mem[k][addr] <= wdata[k];
    end
  end

  // ---------------------------------------------------------------
  // Ripple carry and wide select
  // ---------------------------------------------------------------
  assign mid         = lutOut[0] ? sl.carryIn : sl.route[0];
  assign sum[0]      = lutOut[0] ^ sl.carryIn;
  assign sum[1]      = lutOut[1] ^ mid;
  assign sl.f        = sl.ripple ? sum : lutOut; // RL2
  assign sl.ofx0     = sl.route[`LT_M0] ? lutOut[1] : lutOut[0]; // RL5
  assign sl.carryOut = HAS_REGS &&
                       (lutOut[1] ? mid : sl.route[`LT_LUT_IN]); // RL10

  // ---------------------------------------------------------------
  // Storage registers
  // ---------------------------------------------------------------
  logic sclk;
  logic sclkPrev;
  logic active;
  logic lsr;
  logic [1:0] d;
  assign sclk   = sl.clkNet[sl.route[`LT_CLKSEL]] ^ sl.clkInvert; // RL7 RL8
  assign active = sl.latchMode ? sclk : (sclk & ~sclkPrev); // RL8 RL12
  assign lsr    = sl.route[`LT_LSR];

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      sclkPrev <= 1'b0;
    else
      sclkPrev <= sclk;
  end

  for (genvar k = 0; k < 2; k++)
  begin : g_reg
    assign d[k] = sl.bypass[k] ? wdata[k] : sl.f[k];
    if (HAS_REGS)
    begin : g_on
      logic qr;
      assign sl.q[k] = qr;
      always_ff @(posedge clock or negedge reset_n)
      begin
        if (!reset_n)
          qr <= 1'b0;
        else if (!sl.userMode)
          qr <= sl.initSet[k]; // RL9
        else if (lsr && !sl.syncLsr)
          qr <= sl.initSet[k]; // RL6 RL13
        else if (active && lsr)
          qr <= sl.initSet[k]; // RL6 RL13
        else if (active && sl.route[`LT_CE])
          qr <= d[k]; // RL1 RL7 RL8 RL12
      end
    end
    else
    begin : g_off
      assign sl.q[k] = 1'b0; // RL2
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_enter;
    !sl.userMode ##1 sl.userMode;
  endsequence

  property p_init;
    s_enter |-> sl.q == (HAS_REGS ? $past(sl.initSet) : 2'b00);
  endproperty
  a_init: assert property (p_init) else $error("init state wrong"); // RL9

  property p_async;
    sl.userMode && lsr && !sl.syncLsr && HAS_REGS
      |=> sl.q == $past(sl.initSet);
  endproperty
  a_async: assert property (p_async) else $error("async lsr late"); // RL13

  property p_sync_wait;
    sl.userMode && lsr && sl.syncLsr && !active |=> $stable(sl.q);
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("sync lsr acted early"); // RL6

  property p_load;
    sl.userMode && !lsr && sl.route[`LT_CE] && active && HAS_REGS
      |=> sl.q == $past(d);
  endproperty
  a_load: assert property (p_load) else $error("register load wrong"); // RL8

  property p_hold;
    sl.userMode && !lsr && !active |=> $stable(sl.q);
  endproperty
  a_hold: assert property (p_hold) else $error("register not held"); // RL12

  property p_no_ram;
    sl.userMode && !ramOn |=> mem[0] == $past(mem[0]) &&
                              mem[1] == $past(mem[1]);
  endproperty
  a_no_ram: assert property (p_no_ram) else $error("table changed"); // RL3
endmodule : logic_slice

// ---- logic_slice_tile.sv ----
// Logic tile of four slices facing the routing fabric.
// Assumes synchronous routing inputs and configuration held stable.
//
// Function
// RL1: Slices 0-2: two tables feeding registers
// RL2: Slice 3: two tables, no registers
// RL3: Memory mode only slices 0,2, RAM variant
// RL4: Four slices, 50 inputs, 23 outputs
// RL5: Combine tables into five-to-eight input functions
// RL6: Set/reset selectable synchronous or asynchronous
// RL7: Clock select, chip select, wide functions
// RL8: Register polarity and edge/latch configurable
// RL9: User mode starts from configured init values
// RL10: Slices 0-2: 13 routing plus carry in
// RL11: Slice 3: 13 inputs, four outputs, no carry (code: 10 own inputs, 3 shared with slice 2's controls)
// RL12: Latch passes while active, holds otherwise
// RL13: Sync reset at edge, async immediately
`timescale 1ns/1ns
module logic_slice_tile #(
  parameter bit RAM_TILE = 1'b1
) (
  // Clock and reset
  input  wire logic                                clock,
  input  wire logic                                reset_n,
  // Routing and neighbour tiles
  input  wire logic [`LT_ROUTE_IN-1:0]             routeIn,
  input  wire logic                                carryIn,
  input  wire logic                                wideIn,
  input  wire logic [1:0]                          clkNet,
  output logic      [`LT_ROUTE_OUT-1:0]            routeOut,
  output logic                                     userMode,
  // Configuration
  input  wire logic [`LT_NUM_SLICES-1:0][1:0][`LT_LUT_BITS-1:0] cfgTable,
  input  wire logic [`LT_NUM_SLICES-1:0]           cfgRipple,
  input  wire logic [`LT_NUM_SLICES-1:0]           cfgRamMode,
  input  wire logic [`LT_REG_SLICES-1:0]           cfgClkInvert,
  input  wire logic [`LT_REG_SLICES-1:0]           cfgLatch,
  input  wire logic [`LT_REG_SLICES-1:0]           cfgSyncLsr,
  input  wire logic [`LT_REG_SLICES-1:0][1:0]      cfgInitSet,
  input  wire logic [`LT_REG_SLICES-1:0][1:0]      cfgBypass
);
  logic_tile_pkg::tile_state_t   state;
  logic_tile_pkg::tile_state_t   next_state;
  logic [`LT_ROUTE_OUT-1:0]      next_routeOut;
  logic [`LT_NUM_SLICES-1:0][1:0] f;
  logic [`LT_NUM_SLICES-1:0]     ofx0;
  logic [`LT_NUM_SLICES-1:0][1:0] q;
  logic [`LT_NUM_SLICES:0]       carry;
  logic [`LT_NUM_SLICES-1:0]     m1;
  logic                          lut6a;
  logic                          lut6b;
  logic                          lut7;
  logic                          lut8;
  logic                          isUser;

  // ---------------------------------------------------------------
  // Entry into user mode
  // ---------------------------------------------------------------
  always_comb
  begin
    case (state)
      logic_tile_pkg::TILE_CONFIG: next_state = logic_tile_pkg::TILE_USER;
      default:                     next_state = logic_tile_pkg::TILE_USER;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state <= logic_tile_pkg::TILE_CONFIG;
    else
      state <= next_state; // RL9
  end

  assign isUser   = (state == logic_tile_pkg::TILE_USER);
  assign carry[0] = carryIn;

  // ---------------------------------------------------------------
  // Slices
  // ---------------------------------------------------------------
  for (genvar s = 0; s < `LT_NUM_SLICES; s++)
  begin : g_slice
    localparam bit REGS = (s < `LT_REG_SLICES);
    localparam bit RAM  = RAM_TILE && (s == 0 || s == 2);
    localparam int RS   = REGS ? s : 0;
    slice_if sif ();
    if (REGS)
    begin : g_view
      assign sif.route = routeIn[s*`LT_SLICE_IN +: `LT_SLICE_IN]; // RL10
    end
    else
    begin : g_view3
      assign sif.route = {routeIn[(`LT_REG_SLICES-1)*`LT_SLICE_IN
                                  + `LT_CLKSEL +: `LT_CTRL_W],
                          routeIn[`LT_S3_BASE +: `LT_S3_USED]}; // RL11
    end
    assign sif.carryIn   = REGS ? carry[s] : 1'b0; // RL11
    assign sif.userMode  = isUser;
    assign sif.clkNet    = clkNet;
    assign sif.tableInit = cfgTable[s];
    assign sif.ripple    = cfgRipple[s];
    assign sif.ramMode   = cfgRamMode[s];
    assign sif.clkInvert = REGS && cfgClkInvert[RS];
    assign sif.latchMode = REGS && cfgLatch[RS];
    assign sif.syncLsr   = REGS && cfgSyncLsr[RS];
    assign sif.initSet   = REGS ? cfgInitSet[RS] : 2'b00;
    assign sif.bypass    = REGS ? cfgBypass[RS] : 2'b00;
    assign f[s]          = sif.f;
    assign ofx0[s]       = sif.ofx0;
    assign q[s]          = sif.q;
    assign carry[s+1]    = sif.carryOut;
    assign m1[s]         = sif.route[`LT_M1];

    logic_slice #(
      .HAS_REGS (REGS),
      .RAM_OK   (RAM)
    ) u_slice (
      .clock   (clock),
      .reset_n (reset_n),
      .sl      (sif.slice)
    ); // RL1 RL2 RL3 RL4
  end

  // ---------------------------------------------------------------
  // Wide function combining
  // ---------------------------------------------------------------
  assign lut6a = m1[0] ? ofx0[1] : ofx0[0]; // RL5
  assign lut6b = m1[3] ? ofx0[3] : ofx0[2]; // RL5
  assign lut7  = m1[1] ? lut6b : lut6a; // RL5 RL7
  assign lut8  = routeIn[`LT_WIDE_SEL] ? wideIn : lut7; // RL5

  // ---------------------------------------------------------------
  // Routing outputs
  // ---------------------------------------------------------------
  assign next_routeOut[0 +: `LT_SLICE_OUT] =
           {lut6a, ofx0[0], q[0], f[0]};
  assign next_routeOut[`LT_SLICE_OUT +: `LT_SLICE_OUT] =
           {lut7, ofx0[1], q[1], f[1]};
  assign next_routeOut[2*`LT_SLICE_OUT +: `LT_SLICE_OUT] =
           {lut6b, ofx0[2], q[2], f[2]};
  assign next_routeOut[`LT_S3_OUT_BASE +: `LT_LUT_IN] =
           {lut8, ofx0[3], f[3]}; // RL11
  assign next_routeOut[`LT_CARRY_OUT] = carry[`LT_REG_SLICES]; // RL10

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      routeOut <= '0;
      userMode <= 1'b0;
    end
    else
    begin
      routeOut <= next_routeOut; // RL4
      userMode <= isUser;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_user;
    @(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> ##[1:2] userMode;
  endproperty
  a_user: assert property (p_user) else $error("user mode late"); // RL9

  property p_wide;
    @(posedge clock) disable iff (!reset_n)
    1'b1 |=> routeOut[`LT_S3_OUT_BASE + 3] ==
             $past(routeIn[`LT_WIDE_SEL] ? wideIn : lut7);
  endproperty
  a_wide: assert property (p_wide) else $error("wide output wrong"); // RL5

  property p_carry;
    @(posedge clock) disable iff (!reset_n)
    1'b1 |=> routeOut[`LT_CARRY_OUT] == $past(carry[`LT_REG_SLICES]);
  endproperty
  a_carry: assert property (p_carry) else $error("carry out wrong"); // RL10
endmodule : logic_slice_tile

// ---- routing_fabric.sv ----
// Routing fabric model that drives the tile's routing side.
// Assumes one call of put per clock edge from the bench.
`timescale 1ns/1ns
`include "logic_tile_regs.svh"
module routing_fabric (
  // Clock
  input  wire logic                    clock,
  // Toward the tile
  output logic      [`LT_ROUTE_IN-1:0] routeIn,
  output logic                         carryIn,
  output logic                         wideIn,
  output logic      [1:0]              clkNet
);
  initial
  begin
    routeIn = '0;
    carryIn = 1'b0;
    wideIn  = 1'b0;
    clkNet  = 2'b00;
  end

  // Merge a field into the routing word just after the next edge
  task automatic put(input logic [`LT_ROUTE_IN-1:0] v,
                     input logic [`LT_ROUTE_IN-1:0] m,
                     input logic c, input logic [1:0] k);
    @(posedge clock);
    routeIn <= (routeIn & ~m) | (v & m);
    carryIn <= c;
    clkNet  <= k;
  endtask : put
endmodule : routing_fabric

// ---- test_logic_slice_tile.sv ----
// Self-checking bench for the logic tile.
// Assumes the package, header and slice files are compiled first.
`timescale 1ns/1ns
`include "logic_tile_regs.svh"
module test_logic_slice_tile;
  logic                         clock;
  logic                         reset_n;
  logic [`LT_ROUTE_IN-1:0]      routeIn;
  logic                         carryIn;
  logic                         wideIn;
  logic [1:0]                   clkNet;
  logic [`LT_ROUTE_OUT-1:0]     routeOut;
  logic                         userMode;
  logic [3:0][1:0][15:0]        cfgTable;
  logic [3:0]                   cfgRipple;
  logic [3:0]                   cfgRamMode;
  logic [2:0]                   cfgClkInvert;
  logic [2:0]                   cfgLatch;
  logic [2:0]                   cfgSyncLsr;
  logic [2:0][1:0]              cfgInitSet;
  logic [2:0][1:0]              cfgBypass;
  logic                         cin;
  logic [1:0]                   cn;
  int                           err_total;
  int                           num_checks;

  always #25 clock = ~clock;

  routing_fabric i_routing_fabric (.clock(clock), .routeIn(routeIn),
    .carryIn(carryIn), .wideIn(wideIn), .clkNet(clkNet));

  logic_slice_tile #(.RAM_TILE(1'b1)) i_logic_slice_tile (
    .clock(clock), .reset_n(reset_n), .routeIn(routeIn),
    .carryIn(carryIn), .wideIn(wideIn), .clkNet(clkNet),
    .routeOut(routeOut), .userMode(userMode), .cfgTable(cfgTable),
    .cfgRipple(cfgRipple), .cfgRamMode(cfgRamMode),
    .cfgClkInvert(cfgClkInvert), .cfgLatch(cfgLatch),
    .cfgSyncLsr(cfgSyncLsr), .cfgInitSet(cfgInitSet),
    .cfgBypass(cfgBypass));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic cmp(input string n, input logic [22:0] e,
                     input logic [22:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  task automatic chk(input string n, input logic [22:0] m,
                     input logic [22:0] e);
    cmp(n, e, routeOut & m);
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : settle

  // Slice field is {lsr, ce, csel, m1, m0, a1, a0}
  task automatic fld(input int s, input logic [12:0] f);
    i_routing_fabric.put(50'(f) << (13 * s), 50'h1fff << (13 * s),
                         cin, cn);
  endtask : fld

  task automatic clk(input logic [1:0] k);
    cn = k;
    i_routing_fabric.put('0, '0, cin, cn);
  endtask : clk

  task automatic s3(input logic m0, input logic [3:0] a1,
                    input logic [3:0] a0);
    i_routing_fabric.put(50'({m0, a1, a0}) << `LT_S3_BASE,
                         50'h3ff << `LT_S3_BASE, cin, cn);
  endtask : s3

  task automatic test_done();
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk("reset out", 23'h7fffff, 23'h000000);
    @(posedge clock);
    reset_n <= 1'b1;
    settle(1);
    cmp("user early", 23'h000000, 23'(userMode));
    settle(1);
    cmp("user mode", 23'h000001, 23'(userMode));
    chk("init q", 23'h00c30c, 23'h00c204);
    chk("idle f", 23'h1c0083, 23'h140080);
  endtask : t_reset

  task automatic t_slice3();
    s3(1'b0, 4'h3, 4'hf);
    settle(1);
    chk("s3 table", 23'h1c0000, 23'h140000);
    s3(1'b1, 4'h3, 4'hf);
    settle(1);
    chk("s3 wide", 23'h1c0000, 23'h040000);
    s3(1'b0, 4'h0, 4'h0);
  endtask : t_slice3

  task automatic t_edge();
    fld(2, 13'h0801);
    settle(2);
    chk("no edge", 23'h00c000, 23'h00c000);
    clk(2'b01);
    settle(2);
    chk("edge load", 23'h00c000, 23'h004000);
    fld(2, 13'h0821);
    settle(2);
    chk("edge hold", 23'h00c000, 23'h004000);
    fld(2, 13'h0000);
  endtask : t_edge

  task automatic t_latch();
    fld(1, 13'h0900);
    settle(2);
    chk("latch open", 23'h000100, 23'h000100);
    fld(1, 13'h0800);
    settle(2);
    chk("latch follow", 23'h000100, 23'h000000);
    clk(2'b00);
    fld(1, 13'h0900);
    settle(2);
    chk("latch hold", 23'h000100, 23'h000000);
    fld(1, 13'h0000);
  endtask : t_latch

  task automatic t_lsr();
    fld(0, 13'h0a80);
    clk(2'b01);
    settle(2);
    chk("pre lsr", 23'h00000c, 23'h000008);
    fld(0, 13'h1280);
    fld(2, 13'h1000);
    settle(2);
    chk("lsr wait", 23'h00c00c, 23'h00c008);
    clk(2'b00);
    clk(2'b01);
    settle(2);
    chk("lsr sync", 23'h00000c, 23'h000004);
    fld(0, 13'h0000);
    fld(2, 13'h0000);
  endtask : t_lsr

  task automatic t_ram();
    i_routing_fabric.put(50'h905 | (50'h905 << 13), 50'h3ffffff,
                         cin, cn);
    i_routing_fabric.put(50'h105 | (50'h105 << 13), 50'h3ffffff,
                         cin, cn);
    settle(1);
    chk("ram write", 23'h000041, 23'h000001);
  endtask : t_ram

  task automatic t_carry();
    cin = 1'b1;
    fld(0, 13'h0080);
    settle(1);
    chk("carry a", 23'h000003, 23'h000003);
    fld(0, 13'h0005);
    settle(1);
    chk("carry b", 23'h000003, 23'h000002);
  endtask : t_carry

  initial
  begin
    clock        = 1'b0;
    reset_n      = 1'b0;
    err_total    = 0;
    num_checks   = 0;
    cin          = 1'b0;
    cn           = 2'b00;
    cfgTable     = {16'h6996, 16'h8001, 16'hcccc, 16'haaaa,
                    16'h00ff, 16'h0000, 16'hff00, 16'h0000};
    cfgRipple    = 4'h1;
    cfgRamMode   = 4'h3;
    cfgClkInvert = 3'h0;
    cfgLatch     = 3'h2;
    cfgSyncLsr   = 3'h1;
    cfgInitSet   = 6'h39;
    cfgBypass    = 6'h04;
    repeat (4) @(posedge clock);
    t_reset();
    t_slice3();
    t_edge();
    t_latch();
    t_lsr();
    t_ram();
    t_carry();
    test_done();
  end
endmodule : test_logic_slice_tile
